// >>> testbench/gsp_pad_model.sv
// pad and board model for the port and serial pins
`timescale 1ns/10ps
module gsp_pad_model (
  // clock
  input wire logic sys_clk,
  // design drive
  input wire logic [7:0] portPadOut,
  input wire logic [7:0] portPadOe,
  input wire logic [7:0] portPullEn,
  input wire logic sckPadOut,
  input wire logic sckPadOe,
  input wire logic txdPadOut,
  input wire logic txdPadOe,
  // board drive
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  input wire logic extSck,
  input wire logic extTxd,
  input wire logic extRxd,
  // resolved pin levels
  output logic [7:0] portPadIn,
  output logic sckPadIn,
  output logic txdPadIn,
  output logic rxdPadIn
);
  logic [7:0] floatPat = 8'h00;
  // an undriven, unpulled pin wanders so no stale level can pass a read
  always @(posedge sys_clk) floatPat <= ~floatPat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (portPadOe[i]) portPadIn[i] = portPadOut[i];
      else if (extEn[i]) portPadIn[i] = extVal[i];
      else if (portPullEn[i]) portPadIn[i] = 1'b1;
      else portPadIn[i] = floatPat[i];
    end
  end
  assign sckPadIn = sckPadOe ? sckPadOut : extSck;
  assign txdPadIn = txdPadOe ? txdPadOut : extTxd;
  assign rxdPadIn = extRxd;
endmodule

// >>> testbench/gsp_pin_port_tb.sv
// self-checking bench for the port and serial pin block
`timescale 1ns/10ps
module gsp_pin_port_tb;
  import gsp_pkg::*;
  localparam logic [31:0] A_CTL = 32'hfffffdd8;
  localparam logic [31:0] A_DAT = 32'h3ffffde0;
  localparam logic [31:0] A_SER = 32'hfffffdf0;
  localparam logic [31:0] A_NONE = 32'h00000010;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [31:0] wbAdr = 32'h0, wbDatI = 32'h0, wbDatO, rdat;
  logic [3:0] wbSel = 4'h0;
  logic wbAck;
  logic [7:0] padIn, padOut, padOe, pullEn, laneIn;
  logic [7:0] laneOut = 8'h00, extVal = 8'h00, extEn = 8'h00;
  logic busSel = 1'b0, laneOe = 1'b0, serProg = 1'b0;
  logic sckIn, sckOut, sckOe, txdIn, txdOut, txdOe, rxdIn, asSerial, bootValid;
  logic [2:0] bootPins;
  // boot levels held through reset: rxd 1, txd 0, sck 1
  logic extSck = 1'b1, extTxd = 1'b0, extRxd = 1'b1;
  int badCount = 0;
  int nChecks = 0;

  always #4 sys_clk = ~sys_clk;

  gsp_pin_port gsp_pin_port_inst (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .portPadIn(padIn), .portPadOut(padOut), .portPadOe(padOe), .portPullEn(pullEn), .portAsBusSel(busSel),
    .busLaneOut(laneOut), .busLaneOe(laneOe), .busLaneIn(laneIn), .sckPadIn(sckIn), .sckPadOut(sckOut),
    .sckPadOe(sckOe), .txdPadIn(txdIn), .txdPadOut(txdOut), .txdPadOe(txdOe), .rxdPadIn(rxdIn),
    .serialPinsProgrammed(serProg), .pinsAreSerial(asSerial), .bootModePins(bootPins), .bootModeValid(bootValid));

  gsp_pad_model gsp_pad_model_inst (.sys_clk(sys_clk), .portPadOut(padOut), .portPadOe(padOe),
    .portPullEn(pullEn), .sckPadOut(sckOut), .sckPadOe(sckOe), .txdPadOut(txdOut), .txdPadOe(txdOe),
    .extVal(extVal), .extEn(extEn), .extSck(extSck), .extTxd(extTxd), .extRxd(extRxd), .portPadIn(padIn),
    .sckPadIn(sckIn), .txdPadIn(txdIn), .rxdPadIn(rxdIn));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic testDone();
    $display("checks %0d, mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // reads before the edge's updates land, so ack and data are the sampled values
  task automatic xfer(input logic we, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    wbSel <= s;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    chk("bus ack", 32'h1, {31'h0, wbAck});
    if (wbAck !== 1'b1) begin
      testDone();
    end else begin
      rdat = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    xfer(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [31:0] a);
    xfer(1'b0, a, 32'h0, 4'hf);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic bootMode();
    int n;
    n = 0;
    while (bootValid !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk("boot valid", 32'h1, {31'h0, bootValid});
    chk("boot pins", 32'h5, {29'h0, bootPins});
    chk("serial owned", 32'h0, {31'h0, asSerial});
    serProg <= 1'b1;
    waitCyc(3);
    chk("serial owned", 32'h1, {31'h0, asSerial});
    serProg <= 1'b0;
    waitCyc(3);
  endtask

  task automatic resetValues();
    rd(A_CTL);
    chk("control", 32'h0, rdat);
    chk("pull enable", 32'hff, {24'h0, pullEn});
    chk("port oe", 32'h0, {24'h0, padOe});
    rd(A_SER);
    chk("serial reg", 32'h5, rdat);
  endtask

  task automatic portTraffic();
    wr(A_DAT, 32'ha5, 4'h1);
    wr(A_CTL, 32'h5555, 4'h3);
    waitCyc(2);
    chk("port oe", 32'hff, {24'h0, padOe});
    chk("port out", 32'ha5, {24'h0, padOut});
    chk("pull on output", 32'hff, {24'h0, pullEn});
    rd(A_DAT);
    chk("pin read", 32'ha5, rdat);
    extVal <= 8'h3c;
    extEn <= 8'hff;
    wr(A_CTL, 32'haaaa, 4'h3);
    waitCyc(2);
    chk("pull off", 32'h0, {24'h0, pullEn});
    chk("port oe", 32'h0, {24'h0, padOe});
    rd(A_DAT);
    chk("pin read", 32'h3c, rdat);
    wr(A_CTL, 32'h1234, 4'h1);
    rd(A_CTL);
    chk("control lanes", 32'haa34, rdat);
    wr(A_NONE, 32'hffffffff, 4'hf);
    rd(A_NONE);
    chk("unmapped", 32'h0, rdat);
    extEn <= 8'h00;
    wr(A_CTL, 32'h0, 4'h3);
    waitCyc(3);
    rd(A_DAT);
    chk("pulled pins", 32'hff, rdat);
  endtask

  task automatic serialPins();
    extSck <= 1'b0;
    extRxd <= 1'b0;
    wr(A_SER, 32'h0f, 4'h1);
    waitCyc(2);
    chk("sck drive", 32'h3, {30'h0, sckOe, sckOut});
    chk("txd drive", 32'h3, {30'h0, txdOe, txdOut});
    rd(A_SER);
    chk("serial read", 32'h0e, rdat);
    wr(A_SER, 32'h0a, 4'h1);
    waitCyc(2);
    chk("sck drive", 32'h2, {30'h0, sckOe, sckOut});
    chk("txd drive", 32'h2, {30'h0, txdOe, txdOut});
    extRxd <= 1'b1;
    // the receive pin passes two flops before the read capture sees it
    waitCyc(2);
    rd(A_SER);
    chk("serial read", 32'h0b, rdat);
    extSck <= 1'b1;
    wr(A_SER, 32'h04, 4'h1);
    waitCyc(2);
    chk("sck drive", 32'h0, {30'h0, sckOe, sckOut});
    chk("txd drive", 32'h0, {30'h0, txdOe, txdOut});
    rd(A_SER);
    chk("serial read", 32'h05, rdat);
  endtask

  task automatic portBus();
    laneOut <= 8'h69;
    laneOe <= 1'b1;
    busSel <= 1'b1;
    waitCyc(3);
    chk("bus out", 32'h69, {24'h0, padOut});
    chk("bus oe", 32'hff, {24'h0, padOe});
    waitCyc(3);
    chk("bus in", 32'h69, {24'h0, laneIn});
    busSel <= 1'b0;
    laneOe <= 1'b0;
    waitCyc(2);
  endtask

  // latch survives a power-on reset, control and enables do not
  task automatic resetKeeps();
    wr(A_SER, 32'h0f, 4'h1);
    wr(A_CTL, 32'h5555, 4'h3);
    @(posedge sys_clk);
    resetn <= 1'b0;
    waitCyc(10);
    resetn <= 1'b1;
    waitCyc(6);
    rd(A_CTL);
    chk("control", 32'h0, rdat);
    rd(A_SER);
    chk("serial enables", 32'h0, rdat & 32'h0a);
    wr(A_CTL, 32'h5555, 4'h3);
    waitCyc(2);
    chk("kept latch", 32'ha5, {24'h0, padOut});
  endtask

  initial begin
    waitCyc(10);
    resetn <= 1'b1;
    bootMode();
    resetValues();
    portTraffic();
    serialPins();
    portBus();
    resetKeeps();
    testDone();
  end
endmodule

// >>> verilog/gsp_pin_port.sv
// eight-bit general purpose port plus serial pin port behind classic wishbone
`timescale 1ns/10ps
module gsp_pin_port
  import gsp_pkg::*;
(
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic resetn,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // port pads
  input wire logic [7:0] portPadIn,
  output logic [7:0] portPadOut,
  output logic [7:0] portPadOe,
  output logic [7:0] portPullEn,
  // port-as-data-bus path from the bus controller
  input wire logic portAsBusSel,
  input wire logic [7:0] busLaneOut,
  input wire logic busLaneOe,
  output logic [7:0] busLaneIn,
  // serial clock pad
  input wire logic sckPadIn,
  output logic sckPadOut,
  output logic sckPadOe,
  // serial transmit pad
  input wire logic txdPadIn,
  output logic txdPadOut,
  output logic txdPadOe,
  // serial receive pad
  input wire logic rxdPadIn,
  // serial controller ownership and boot mode
  input wire logic serialPinsProgrammed,
  output logic pinsAreSerial,
  output logic [2:0] bootModePins,
  output logic bootModeValid
);
  // ----------------------------------------
  // pad input synchronisers
  // ----------------------------------------
  logic [10:0] padRaw;
  logic [10:0] padSync;
  logic [7:0] portPinLvl;
  logic sckLvl;
  logic txdLvl;
  logic rxdLvl;

  assign padRaw = {rxdPadIn, txdPadIn, sckPadIn, portPadIn};

  gsp_sync #(
    .WIDTH(11)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn(padRaw),
    .syncOut(padSync)
  );

  assign portPinLvl = padSync[7:0];
  assign sckLvl = padSync[8];
  assign txdLvl = padSync[9];
  assign rxdLvl = padSync[10];

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic ack_r;
  logic busReq;
  logic newReq;
  logic wrStrobe;
  logic hitCtrl;
  logic hitData;
  logic hitSer;

  assign busReq = wb_cyc_i & wb_stb_i;
  assign newReq = busReq & ~ack_r;
  // writes land on the edge where the master sees ack
  assign wrStrobe = busReq & wb_we_i & ack_r;
  assign hitCtrl = wb_adr_i[31:2] == GSP_CTRL_IDX[29:0];
  assign hitData = wb_adr_i[31:2] == GSP_DATA_IDX[29:0];
  assign hitSer = wb_adr_i[31:2] == GSP_SER_IDX[29:0];

  // ----------------------------------------
  // port control register
  // ----------------------------------------
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  // nets, since the generate loop below drives them one bit per assignment
  wire logic [7:0] dirBits;
  wire logic [7:0] pupBits;

  assign ctrl_nxt = {wb_sel_i[1] ? wb_dat_i[15:8] : ctrl_r[15:8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_r[7:0]};

  // only power-on reset reaches this; manual reset and standby leave it alone
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= GSP_CTRL_RST;
    end else if (wrStrobe && hitCtrl) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // interleaved fields split per bit
  genvar gi;
  generate
    for (gi = 0; gi < GSP_PORT_W; gi++) begin : g_fields
      assign dirBits[gi] = ctrl_r[2*gi+GSP_DIR_OFS];
      assign pupBits[gi] = ctrl_r[2*gi+GSP_PUP_OFS];
    end
  endgenerate

  // ----------------------------------------
  // port data latch
  // ----------------------------------------
  logic [7:0] dataLatch_r;

  // no reset at all: contents survive every reset; software must load it first
  always_ff @(posedge sys_clk) begin
    if (wrStrobe && hitData && wb_sel_i[0]) begin
      dataLatch_r <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------
  // serial pin port register
  // ----------------------------------------
  logic sckOeBit_r;
  logic txdOeBit_r;
  logic sckDataBit_r;
  logic brkDataBit_r;
  logic serWr;

  assign serWr = wrStrobe & hitSer & wb_sel_i[0];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {sckOeBit_r, txdOeBit_r} <= GSP_SER_OE_RST;
    end else if (serWr) begin
      sckOeBit_r <= wb_dat_i[GSP_CLK_OE];
      txdOeBit_r <= wb_dat_i[GSP_TXD_OE];
    end
  end

  // data bits 2 and 0 come up undefined after power-on
  always_ff @(posedge sys_clk) begin
    if (serWr) begin
      sckDataBit_r <= wb_dat_i[GSP_CLK_DATA];
      brkDataBit_r <= wb_dat_i[GSP_BRK_DATA];
    end
  end

  // ----------------------------------------
  // read mux and bus answer
  // ----------------------------------------
  logic [31:0] rdMux;
  logic [3:0] serRead;

  // bits 2 and 0 show pins, not the stored drive values
  assign serRead = {sckOeBit_r, sckLvl, txdOeBit_r, rxdLvl};
  assign rdMux = hitCtrl ? {16'h0000, ctrl_r} :
                 hitData ? {24'h000000, portPinLvl} :
                 hitSer ? {28'h0000000, serRead} :
                 32'h00000000;

  // one wait state; unmapped addresses are acked with zero data
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_r <= newReq;
      if (newReq && !wb_we_i) begin
        wb_dat_o <= rdMux;
      end
    end
  end

  assign wb_ack_o = ack_r;

  // ----------------------------------------
  // port pad drive
  // ----------------------------------------
  logic [7:0] padOut_nxt;
  logic [7:0] padOe_nxt;
  logic [7:0] padOut_r;
  logic [7:0] padOe_r;
  logic [7:0] pullEn_r;
  logic [7:0] laneIn_r;

  // bus lanes take the pins over; the latch output is masked so an
  // undefined latch never reaches a pin that is not driven
  assign padOut_nxt = portAsBusSel ? busLaneOut : (dirBits & dataLatch_r);
  assign padOe_nxt = portAsBusSel ? {8{busLaneOe}} : dirBits;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      padOut_r <= 8'h00;
      padOe_r <= 8'h00;
      pullEn_r <= 8'h00;
      laneIn_r <= 8'h00;
    end else begin
      padOut_r <= padOut_nxt;
      padOe_r <= padOe_nxt;
      pullEn_r <= ~pupBits;
      laneIn_r <= portPinLvl;
    end
  end

  assign portPadOut = padOut_r;
  assign portPadOe = padOe_r;
  assign portPullEn = pullEn_r;
  assign busLaneIn = laneIn_r;

  // ----------------------------------------
  // serial pad drive
  // ----------------------------------------
  logic sckOut_r;
  logic sckOe_r;
  logic txdOut_r;
  logic txdOe_r;

  // the serial controller itself is muxed in outside; software has to park
  // it before using these pins as port outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sckOut_r <= 1'b0;
      sckOe_r <= 1'b0;
      txdOut_r <= 1'b0;
      txdOe_r <= 1'b0;
    end else begin
      sckOe_r <= sckOeBit_r;
      sckOut_r <= sckOeBit_r & sckDataBit_r;
      txdOe_r <= txdOeBit_r;
      txdOut_r <= txdOeBit_r & brkDataBit_r;
    end
  end

  assign sckPadOut = sckOut_r;
  assign sckPadOe = sckOe_r;
  assign txdPadOut = txdOut_r;
  assign txdPadOe = txdOe_r;

  // ----------------------------------------
  // boot mode capture
  // ----------------------------------------
  logic [1:0] bootWait_r;
  logic [2:0] bootMode_r;
  logic bootValid_r;
  logic serialOwn_r;
  logic bootCatch;

  // wait until the synchronisers hold post-reset pad levels
  assign bootCatch = (bootWait_r == GSP_BOOT_WAIT) & ~bootValid_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bootWait_r <= 2'h0;
      bootMode_r <= 3'h0;
      bootValid_r <= 1'b0;
      serialOwn_r <= 1'b0;
    end else begin
      if (bootWait_r != GSP_BOOT_WAIT) begin
        bootWait_r <= bootWait_r + 2'h1;
      end
      if (bootCatch) begin
        bootMode_r <= {rxdLvl, txdLvl, sckLvl};
        bootValid_r <= 1'b1;
      end
      serialOwn_r <= bootValid_r & serialPinsProgrammed;
    end
  end

  assign bootModePins = bootMode_r;
  assign bootModeValid = bootValid_r;
  assign pinsAreSerial = serialOwn_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence readCtrl_s;
    newReq && !wb_we_i && hitCtrl;
  endsequence

  sequence readData_s;
    newReq && !wb_we_i && hitData;
  endsequence

  sequence readSer_s;
    newReq && !wb_we_i && hitSer;
  endsequence

  dir_to_oe_a: assert property (!portAsBusSel |=> portPadOe == $past(dirBits))
    else $error("port output enable does not follow direction bits");

  // the register still holds its reset value one edge after release, so start from a running cycle
  pull_follow_a: assert property (resetn |=> portPullEn == ~$past(pupBits))
    else $error("pull-up enable does not follow control bits");

  pull_on_output_a: assert property (dirBits[0] && !pupBits[0] |=> portPullEn[0])
    else $error("pull-up dropped on an output pin");

  latch_drive_a: assert property (!portAsBusSel && dirBits == 8'hff |=> portPadOut == $past(dataLatch_r))
    else $error("output pins do not carry the data latch");

  data_read_pin_a: assert property (readData_s |=> wb_ack_o && wb_dat_o == {24'h000000, $past(portPinLvl)})
    else $error("data read does not return pin levels");

  ctrl_read_back_a: assert property (readCtrl_s |=> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[15:0] == $past(ctrl_r))
    else $error("control read back mismatch");

  bus_lane_a: assert property (portAsBusSel && busLaneOe |=> portPadOut == $past(busLaneOut) && portPadOe == 8'hff)
    else $error("bus lanes not driven onto port pins");

  ser_reserved_a: assert property (readSer_s |=> wb_dat_o[31:4] == 28'h0000000)
    else $error("reserved serial bits read non-zero");

  sck_drive_a: assert property (sckOeBit_r |=> sckPadOe && sckPadOut == $past(sckDataBit_r))
    else $error("clock pin not driven from its data bit");

  sck_read_a: assert property (readSer_s |=> wb_dat_o[GSP_CLK_DATA] == $past(sckLvl))
    else $error("bit 2 does not read clock pin");

  txd_drive_a: assert property (txdOeBit_r |=> txdPadOe && txdPadOut == $past(brkDataBit_r))
    else $error("transmit pin not driven from break bit");

  txd_quiet_a: assert property (!txdOeBit_r |=> !txdPadOe)
    else $error("transmit pin driven while disabled");

  rxd_read_a: assert property (readSer_s |=> wb_dat_o[GSP_BRK_DATA] == $past(rxdLvl))
    else $error("bit 0 does not read receive pin");

  boot_capture_a: assert property (bootCatch |=> bootModeValid && bootModePins == $past({rxdLvl, txdLvl, sckLvl}))
    else $error("boot mode not captured");

  serial_gate_a: assert property (!bootModeValid |=> !pinsAreSerial)
    else $error("pins turned serial before boot capture");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
endmodule

// >>> verilog/gsp_pkg.sv
// constants for the eight-bit port and the serial pin port
// How it works
// - direction bit 2n: 0 input, 1 output
// - pull-up bit 2n+1: 0 pulled up, 1 not
// - pull-up applies whatever the pin direction
// - output pins drive the data latch bit
// - data reads return synchronised pin levels
// - control clears on power-on reset only
// - data latch is never initialised
// - bus-select bit turns pins into data lines
// - serial register bits 7..4 read zero
// - clock enable bit drives clock data bit out
// - bit 2 reads the clock pin level
// - transmit enable bit drives bit 0 out
// - bit 0 reads the receive pin level
// - serial pins are boot inputs after reset
// - serial register clears except bits 2, 0
package gsp_pkg;
  // ----------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [31:0] GSP_CTRL_IDX = 32'hffffff76;
  localparam logic [31:0] GSP_DATA_IDX = 32'h0fffff78;
  localparam logic [31:0] GSP_SER_IDX = 32'hffffff7c;
  // ----------------------------------------
  // field positions and widths
  // ----------------------------------------
  localparam int GSP_PORT_W = 8;
  localparam int GSP_CTRL_W = 16;
  localparam int GSP_SER_W = 4;
  localparam int GSP_DIR_OFS = 0;
  localparam int GSP_PUP_OFS = 1;
  localparam int GSP_BRK_DATA = 0;
  localparam int GSP_TXD_OE = 1;
  localparam int GSP_CLK_DATA = 2;
  localparam int GSP_CLK_OE = 3;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] GSP_CTRL_RST = 16'h0000;
  localparam logic [1:0] GSP_SER_OE_RST = 2'h0;
  // ----------------------------------------
  // timing: synchroniser depth and boot capture wait
  // ----------------------------------------
  localparam int GSP_SYNC_STAGES = 2;
  localparam logic [1:0] GSP_BOOT_WAIT = 2'h3;
endpackage

// >>> verilog/gsp_sync.sv
// two-flop synchroniser for pad inputs
`timescale 1ns/10ps
module gsp_sync
  import gsp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // async level in, synchronous level out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  // the first stage feeds only the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      stable_r <= '0;
    end else begin
      meta_r <= asyncIn;
      stable_r <= meta_r;
    end
  end

  assign syncOut = stable_r;
endmodule
